/* src/sdp_dio_port.sv */
// Operation
// - eight-bit port read and written directly, no strobes or handshakes.
// - each line has its own direction and driven level.
// - with hardware shifting off, control bit 11 drives serial clock manually.
// - control bit 10 picks serial clock: 1.2 us period or 100 kHz.
// - bit 9 enables shifter; clock on line 4, data on line 0.
// - bit 8 starts shifting the serial byte out, bit 0 first.
// - start also captures incoming serial bits into serial input register.
// - start bit clears itself when the conversion ends.
// - separate status register shows whether a conversion is still running.
// - control bits 7..0 enable line drive; a cleared bit leaves its pin an input.
// - drive-enable bits ignored where pin configuration owns output enable.
// - output bits 15..8 hold the next serial byte, pins unchanged.
// - output bits 7..0 update enabled port lines at once, except line 4, lines whose pin configuration owns output enable and, with the shifter on, line 0.
// - register 0x00e returns live line levels in low byte, upper zero.
// - serial input register low byte holds the received byte after conversion.
// - after reset no line is driven except where pin configuration owns output enable.
`timescale 1ns/1ps
`default_nettype none
module sdp_dio_port #(
	parameter int SER_DIN_LINE = sdp_pkg::SER_DIN_LINE_DEF,
	parameter int FAST_HALF_P  = sdp_pkg::FAST_HALF,
	parameter int SLOW_HALF_P  = sdp_pkg::SLOW_HALF
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	// register access
	input  wire sdp_pkg::sdp_bus_req_t bus_req,
	output logic [15:0]               bus_rdata,
	// per-pin configuration ownership of output enable
	input  wire logic [7:0]           cfg_owns_oe,
	input  wire logic [7:0]           cfg_oe,
	input  wire logic [7:0]           cfg_out,
	// port lines
	input  wire logic [7:0]           port_in,
	output var sdp_pkg::sdp_pins_t    port_line
);
	import sdp_pkg::*;

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [15:0] ctrl_r;
	logic [15:0] out_r;
	logic [15:0] rdata_r;
	logic        wr_ctrl;
	logic        wr_out;
	logic        half_tick;
	logic        ser_clk;
	logic        ser_dout;
	logic        active;
	logic        done;
	logic [7:0]  rx_byte;
	logic        hw_en;
	logic [7:0]  drive_val;
	logic [7:0]  drive_en;

	assign wr_ctrl = bus_req.wr && (bus_req.addr == OFF_PORT_CTRL);
	assign wr_out  = bus_req.wr && (bus_req.addr == OFF_PORT_OUT_SHIFT);
	assign hw_en   = ctrl_r[CTRL_HW_ENABLE_BIT];

	// control register; reset leaves every line not owned by pin configuration undriven
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= {4'h0, bus_req.wdata[11:0]};
		end else if (done) begin
			ctrl_r[CTRL_START_BIT] <= 1'b0;
		end
	end

	// output register, direct writes
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			out_r <= OUT_RESET;
		end else if (wr_out) begin
			out_r <= bus_req.wdata;
		end
	end

	// ****************************************************************
	// serial shifter
	// ****************************************************************
	sdp_rate_gen #(
		.FAST_HALF_P (FAST_HALF_P),
		.SLOW_HALF_P (SLOW_HALF_P)
	) u_rate (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.run       (active),
		.slow_sel  (ctrl_r[CTRL_TIMEBASE_BIT]),
		.half_tick (half_tick)
	);

	sdp_shifter u_shift (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.start     (hw_en && ctrl_r[CTRL_START_BIT]),
		.tx_byte   (out_r[15:8]),
		.half_tick (half_tick),
		.ser_din   (port_in[SER_DIN_LINE]),
		.ser_clk   (ser_clk),
		.ser_dout  (ser_dout),
		.active    (active),
		.done      (done),
		.rx_byte   (rx_byte)
	);

	// ****************************************************************
	// pin drive
	// ****************************************************************
	always_comb begin
		drive_val = out_r[7:0];
		if (hw_en) begin
			drive_val[SER_CLK_LINE]  = ser_clk;
			drive_val[SER_DOUT_LINE] = ser_dout;
		end else begin
			drive_val[SER_CLK_LINE] = ctrl_r[CTRL_MANUAL_CLK_BIT];
		end
		for (int i = 0; i < 8; i++) begin
			if (cfg_owns_oe[i]) begin
				drive_en[i]  = cfg_oe[i];
				drive_val[i] = cfg_out[i];
			end else begin
				drive_en[i] = ctrl_r[i];
			end
		end
	end

	// one driver for the whole carrier
	assign port_line = '{in: port_in, out: drive_val, oe: drive_en};

	// ****************************************************************
	// read path
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_r <= READ_ZERO;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				OFF_PORT_LEVEL_IN: rdata_r <= {8'h00, port_in};
				OFF_SHIFTED_IN:    rdata_r <= {8'h00, rx_byte};
				OFF_SHIFT_STATUS:  rdata_r <= {15'h0000, active};
				default:           rdata_r <= READ_ZERO;
			endcase
		end
	end

	assign bus_rdata = rdata_r;
endmodule : sdp_dio_port
`default_nettype wire

/* src/sdp_pkg.sv */
package sdp_pkg;

	// ****************************************************************
	// register map and fields
	// ****************************************************************
	localparam int          ADDR_W              = 12;
	localparam logic [11:0] OFF_PORT_LEVEL_IN   = 12'h00e;
	localparam logic [11:0] OFF_PORT_OUT_SHIFT  = 12'h014;
	localparam logic [11:0] OFF_PORT_CTRL       = 12'h016;
	localparam logic [11:0] OFF_SHIFTED_IN      = 12'h038;
	localparam logic [11:0] OFF_SHIFT_STATUS    = 12'h03a;
	localparam int          CTRL_MANUAL_CLK_BIT = 11;
	localparam int          CTRL_TIMEBASE_BIT   = 10;
	localparam int          CTRL_HW_ENABLE_BIT  = 9;
	localparam int          CTRL_START_BIT      = 8;
	localparam int          STATUS_ACTIVE_BIT   = 0;
	localparam int          SER_CLK_LINE        = 4;
	localparam int          SER_DOUT_LINE       = 0;
	localparam int          SER_DIN_LINE_DEF    = 1;
	localparam logic [15:0] CTRL_RESET          = 16'h0000;
	localparam logic [15:0] OUT_RESET           = 16'h0000;
	localparam logic [7:0]  BYTE_RESET          = 8'h00;
	localparam logic [15:0] READ_ZERO           = 16'h0000;
	localparam int          SHIFT_BITS          = 8;

	// ****************************************************************
	// serial clock timing
	// ****************************************************************
	localparam real CLK_NS        = 4.0;
	localparam real FAST_PER_NS   = 1200.0;
	localparam real SLOW_FREQ_KHZ = 100.0;
	localparam int  FAST_CYC      = int'(FAST_PER_NS / CLK_NS);
	localparam int  SLOW_CYC      = int'(1.0e6 / (SLOW_FREQ_KHZ * CLK_NS));
	localparam int  FAST_HALF     = FAST_CYC / 2;
	localparam int  SLOW_HALF     = SLOW_CYC / 2;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [15:0] wdata;
	} sdp_bus_req_t;

	typedef struct packed {
		logic [7:0] in;
		logic [7:0] out;
		logic [7:0] oe;
	} sdp_pins_t;

endpackage : sdp_pkg

/* src/sdp_rate_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module sdp_rate_gen #(
	parameter int FAST_HALF_P = 150,
	parameter int SLOW_HALF_P = 1250
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// control
	input  wire logic run,
	input  wire logic slow_sel,
	// half period ticks
	output logic      half_tick
);
	import sdp_pkg::*;

	logic [15:0] cnt_r;
	logic [15:0] lim;

	assign lim       = slow_sel ? 16'(SLOW_HALF_P - 1) : 16'(FAST_HALF_P - 1);
	assign half_tick = run && (cnt_r >= lim);

	always_ff @(posedge core_clk) begin
		if (sys_rst || !run || half_tick) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule : sdp_rate_gen
`default_nettype wire

/* src/sdp_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module sdp_shifter (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// control
	input  wire logic       start,
	input  wire logic [7:0] tx_byte,
	input  wire logic       half_tick,
	input  wire logic       ser_din,
	// serial outputs
	output logic            ser_clk,
	output logic            ser_dout,
	output logic            active,
	output logic            done,
	output logic [7:0]      rx_byte
);
	import sdp_pkg::*;

	logic [7:0] tx_r;
	logic [7:0] rx_r;
	logic [3:0] cnt_r;
	logic       clk_r;
	logic       act_r;

	assign ser_clk  = clk_r;
	assign ser_dout = tx_r[0];
	assign active   = act_r;
	assign rx_byte  = rx_r;
	assign done     = act_r && half_tick && clk_r && (cnt_r == 4'(SHIFT_BITS - 1));

	// lsb first, data changes on falling edge, sampled on rising edge
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_r  <= BYTE_RESET;
			rx_r  <= BYTE_RESET;
			cnt_r <= 4'h0;
			clk_r <= 1'b0;
			act_r <= 1'b0;
		end else if (!act_r) begin
			if (start) begin
				tx_r  <= tx_byte;
				cnt_r <= 4'h0;
				clk_r <= 1'b0;
				act_r <= 1'b1;
			end
		end else if (half_tick) begin
			clk_r <= !clk_r;
			if (!clk_r) begin
				rx_r <= {ser_din, rx_r[7:1]};
			end else begin
				tx_r  <= {1'b0, tx_r[7:1]};
				cnt_r <= cnt_r + 4'h1;
				if (done) begin
					act_r <= 1'b0;
				end
			end
		end
	end
endmodule : sdp_shifter
`default_nettype wire

/* sim/sdp_dio_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sdp_chk (
	// clock and reset
	input wire logic                  core_clk,
	input wire logic                  sys_rst,
	// bus and lines
	input wire sdp_pkg::sdp_bus_req_t bus_req,
	input wire logic [15:0]           bus_rdata,
	input wire logic [7:0]            cfg_owns_oe,
	input wire logic [7:0]            cfg_oe,
	input wire logic [7:0]            cfg_out,
	input wire logic [7:0]            port_in,
	input wire sdp_pkg::sdp_pins_t    port_line
);
	import sdp_pkg::*;
	// ****************
	// properties
	// ****************
	logic            hw_r;
	logic            sb0_r;
	wire logic       wc = bus_req.wr && bus_req.addr == OFF_PORT_CTRL;
	wire logic       wo = bus_req.wr && bus_req.addr == OFF_PORT_OUT_SHIFT;
	wire logic [7:0] fr = ~cfg_owns_oe & (hw_r ? 8'hee : 8'hef);
	always_ff @(posedge core_clk) begin
		if (sys_rst) hw_r <= 1'b0;
		else if (wc) hw_r <= bus_req.wdata[CTRL_HW_ENABLE_BIT];
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) sb0_r <= 1'b0;
		else if (wo) sb0_r <= bus_req.wdata[8];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_go; wc && bus_req.wdata[9:8] == 2'h3; endsequence
	sequence s_bit0; !port_line.out[SER_CLK_LINE] && port_line.out[SER_DOUT_LINE] == sb0_r; endsequence
	a_in_copy: assert property (port_line.in == port_in)
		else $error("in copy");
	a_cfg_owns_oe: assert property ((port_line.oe & cfg_owns_oe) == (cfg_oe & cfg_owns_oe))
		else $error("cfg oe");
	a_reset_quiet: assert property ($fell(sys_rst) |-> (port_line.oe & ~cfg_owns_oe) == 8'h00)
		else $error("oe after reset");
	a_rdata_hold: assert property (!bus_req.rd |=> $stable(bus_rdata))
		else $error("rdata moved");
	a_level_read: assert property (bus_req.rd && bus_req.addr == OFF_PORT_LEVEL_IN |=>
		bus_rdata == {8'h00, $past(port_in)}) else $error("level read");
	a_ctrl_oe: assert property (wc |=> (port_line.oe & ~cfg_owns_oe) ==
		($past(bus_req.wdata[7:0]) & ~cfg_owns_oe)) else $error("ctrl oe");
	a_par_out: assert property (wo |=> (port_line.out & port_line.oe & fr) ==
		($past(bus_req.wdata[7:0]) & port_line.oe & fr)) else $error("par out");
	a_manual_clk: assert property (wc && !bus_req.wdata[9] && !cfg_owns_oe[SER_CLK_LINE] |=>
		port_line.out[SER_CLK_LINE] == $past(bus_req.wdata[11])) else $error("manual clk");
	a_start_bit0: assert property (s_go |=> s_bit0)
		else $error("first bit");
endmodule : sdp_chk
bind sdp_dio_port sdp_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .cfg_owns_oe(cfg_owns_oe), .cfg_oe(cfg_oe), .cfg_out(cfg_out),
	.port_in(port_in), .port_line(port_line));
`default_nettype wire

/* sim/sdp_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdp_ext_model (
	// clock and reset
	input wire logic               core_clk,
	input wire logic               sys_rst,
	// far side
	input wire logic [7:0]         ext_lvl,
	input wire logic [7:0]         ser_byte,
	input wire sdp_pkg::sdp_pins_t pins,
	output logic [7:0]             port_in
);
	import sdp_pkg::*;
	// ****************
	// serial source
	// ****************
	logic [2:0] idx_r;
	logic       sck_q;
	logic [7:0] far;
	always_ff @(posedge core_clk) begin
		sck_q <= pins.out[SER_CLK_LINE];
		if (sys_rst) idx_r <= 3'h0;
		else if (pins.oe[SER_CLK_LINE] && pins.out[SER_CLK_LINE] && !sck_q) idx_r <= idx_r + 3'h1;
	end
	always_comb begin
		far = ext_lvl;
		far[SER_DIN_LINE_DEF] = ser_byte[idx_r];
	end
	assign port_in = (pins.oe & pins.out) | (~pins.oe & far);
endmodule : sdp_ext_model
`default_nettype wire

/* sim/sdp_dio_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sdp_dio_port_test;
	import sdp_pkg::*;
	// ****************
	// bench
	// ****************
	logic         core_clk = 1'b0;
	logic         sys_rst = 1'b1;
	sdp_bus_req_t rq = '0;
	logic [15:0]  rd, ctl;
	logic [7:0]   own = 8'h00, coe = 8'h00, cout = 8'h00, ext = 8'h00;
	logic [7:0]   pin, outb, eoe, elv, tx = 8'h00;
	sdp_pins_t    pl;
	logic         sq = 1'b0;
	int           rises = 0, fails = 0, checks_done = 0;
	logic [71:0]  rows [6] = '{72'h00000000ff3c00ff2c, 72'h000000000fff000f0f, 72'hf0a080000f0555afd5,
		72'hff00ff00ffff5a005a, 72'h0000000000ffc300c3, 72'h000000081000001010};
	always #2 core_clk = ~core_clk;
	sdp_dio_port #(.FAST_HALF_P(2), .SLOW_HALF_P(4)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.bus_req(rq), .bus_rdata(rd), .cfg_owns_oe(own), .cfg_oe(coe), .cfg_out(cout),
		.port_in(pin), .port_line(pl));
	sdp_ext_model u_ext (.core_clk(core_clk), .sys_rst(sys_rst), .ext_lvl(ext), .ser_byte(8'ha5),
		.pins(pl), .port_in(pin));
	always @(posedge core_clk) begin
		if (pl.oe[4] && pl.out[4] && !sq) begin
			rises <= rises + 1;
			tx <= {pl.out[0], tx[7:1]};
		end
		sq <= pl.out[4];
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge core_clk);
		#1;
		rq = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge core_clk);
		#1;
		rq = '0;
	endtask : bus
	task automatic ser(input logic [15:0] c, input int h);
		int n;
		rises = 0;
		bus(1'b1, OFF_PORT_OUT_SHIFT, 16'h9600);
		chk("pins", {8'h00, pl.out & 8'hee}, 16'h0000);
		bus(1'b1, OFF_PORT_CTRL, c);
		bus(1'b0, OFF_SHIFT_STATUS, 16'h0000);
		chk("busy", {15'h0000, rd[0]}, 16'h0001);
		n = 1;
		while (rd[0] !== 1'b0 && n < 200) begin
			bus(1'b0, OFF_SHIFT_STATUS, 16'h0000);
			n++;
		end
		chk("period", {15'h0000, n * 2 >= 16 * h - 2 && n * 2 <= 16 * h + 6}, 16'h0001);
		chk("rises", 16'(rises), 16'h0008);
		chk("tx", {8'h00, tx}, 16'h0096);
		bus(1'b0, OFF_SHIFTED_IN, 16'h0000);
		chk("rx", rd, 16'h00a5);
	endtask : ser
	initial begin
		#20000;
		fails++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		chk("oe", {8'h00, pl.oe}, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			{own, coe, cout, ctl, outb, ext, eoe, elv} = rows[i];
			bus(1'b1, OFF_PORT_CTRL, ctl);
			bus(1'b1, OFF_PORT_OUT_SHIFT, {8'h00, outb});
			bus(1'b0, OFF_PORT_LEVEL_IN, 16'h0000);
			chk("oe", {8'h00, pl.oe}, {8'h00, eoe});
			chk("level", rd, {8'h00, elv});
		end
		sys_rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		chk("oe", {8'h00, pl.oe}, 16'h0000);
		ser(16'h0311, 2);
		ser(16'h0711, 4);
		bus(1'b1, OFF_PORT_CTRL, 16'h0101);
		bus(1'b0, OFF_SHIFT_STATUS, 16'h0000);
		chk("idle", {15'h0000, rd[0]}, 16'h0000);
		bus(1'b0, 12'h020, 16'h0000);
		chk("unmapped", rd, READ_ZERO);
		wrap_up();
	end
endmodule : sdp_dio_port_test
`default_nettype wire
